/* File: hw/tbid_pkg.sv */
// Summary of operation
// RQ1 - byte ops: opcode, destination bit, file address
// RQ2 - bit ops: opcode, bit number, file
// RQ3 - literal ops: opcode and eight-bit immediate
// RQ4 - top bits 101: nine-bit jump, two cycles
// RQ5 - add and subtract update carry, digit, zero
// RQ6 - logic, move, inc, dec update zero only
// RQ7 - rotates change carry; swap changes nothing
// RQ8 - inc/dec skip on zero, two cycles
// RQ9 - bit test skips on clear or set
// RQ10 - literal logic updates zero; load changes none
// RQ11 - call and literal return take two cycles
// RQ12 - standby, watchdog clear, option load words
// RQ13 - program counter writes except jump clear bit8
// RQ14 - port self-modify reads pin levels
// RQ15 - direction latch load for ports a, b
// RQ16 - timer writeback clears assigned prescaler
// RQ17 - cycle is four oscillator periods
// RQ18 - standby sets timeout, clears powerdown, stops osc
// RQ19 - clear file, clear work, move work, no-op
// RQ20 - unknown words execute as single-cycle no-op
package tbid_pkg;
    localparam int TBID_PHASES = 4;
    localparam logic [4:0] TBID_TIMER_ADDR = 5'h0_001;
    localparam logic [4:0] TBID_PORT_A_REGISTER_ADDR = 5'h0_005;
    localparam logic [4:0] TBID_PORT_B_REGISTER_ADDR = 5'h0_006;
    localparam logic [4:0] TBID_PORTC_ADDR = 5'h0_007;
    localparam logic [1:0] TBID_PHASE_RST = 2'h0;
    localparam int TBID_WB_ADDR_W = 4;
    localparam logic [3:0] TBID_REG_INSTR = 4'h0;
    localparam logic [3:0] TBID_REG_CTRL = 4'h4;
    localparam logic [3:0] TBID_REG_STATUS = 4'h8;
    localparam logic [3:0] TBID_REG_DECODE = 4'hC;

    typedef enum logic [2:0] {
        TBID_DST_NONE, TBID_DST_W, TBID_DST_F, TBID_DST_LOAD_DIRECTION_LATCH_A,
        TBID_DST_LOAD_DIRECTION_LATCH_B, TBID_DST_OPTION
    } tbid_dst_t;

    typedef enum logic [4:0] {
        TBID_ALU_NOP, TBID_ALU_ADD, TBID_ALU_SUB, TBID_ALU_AND, TBID_ALU_OR,
        TBID_ALU_XOR, TBID_ALU_COM, TBID_ALU_DEC, TBID_ALU_INC,
        TBID_ALU_MOVE_FILE, TBID_ALU_RL, TBID_ALU_RR, TBID_ALU_SWAP,
        TBID_ALU_CLR, TBID_ALU_PASSW, TBID_ALU_BCLR, TBID_ALU_BSET,
        TBID_ALU_BTST, TBID_ALU_LIT
    } tbid_alu_t;

    typedef struct packed {
        tbid_alu_t alu_op;
        tbid_dst_t dst;
        logic [4:0] file_addr;
        logic [2:0] bit_num;
        logic [7:0] literal;
        logic use_literal;
        logic upd_c;
        logic upd_dc;
        logic upd_z;
        logic skip_if_zero;
        logic skip_if_clear;
        logic skip_if_set;
        logic jump;
        logic call;
        logic ret;
        logic [8:0] jump_target;
        logic pc_bit8_clr;
        logic read_pins;
        logic clr_prescaler;
        logic standby;
        logic wdt_clear;
        logic illegal;
    } tbid_ctl_t;
endpackage : tbid_pkg

/* File: hw/tbid_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module tbid_decoder
    import tbid_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // instruction from program memory
    input wire logic [11:0] instr,
    input wire logic instr_valid,
    // execution feedback
    input wire logic alu_zero,
    input wire logic bit_value,
    input wire logic prescaler_on_timer,
    // decoded controls
    output tbid_ctl_t ctl_out,
    output logic ctl_valid,
    output logic [1:0] phase,
    output logic flush_next,
    output logic osc_stop,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic ready,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [TBID_WB_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o
);
    tbid_ctl_t dec;
    tbid_ctl_t ctl_ff;
    logic ctl_valid_ff;
    logic [1:0] phase_ff;
    logic second_ff;
    logic flush_ff;
    logic osc_stop_ff;
    logic timeout_ff;
    logic powerdown_ff;
    logic halt_ff;
    logic [11:0] last_instr_ff;
    logic ack_ff;
    logic err_ff;
    logic [31:0] rdata_ff;
    logic [5:0] op6;
    logic [3:0] op4;
    logic fmt_file;
    logic is_port;
    logic cycle_end;
    logic two_cycle;
    logic wb_req;
    logic wb_hit;

    assign op6 = instr[11:6];
    assign op4 = instr[11:8];
    assign is_port = (instr[4:0] == TBID_PORT_A_REGISTER_ADDR) ||
        (instr[4:0] == TBID_PORT_B_REGISTER_ADDR) || (instr[4:0] == TBID_PORTC_ADDR);

    always_comb begin
        dec = '0;
        dec.alu_op = TBID_ALU_NOP;
        dec.dst = TBID_DST_NONE;
        fmt_file = 1'b0;
        dec.file_addr = instr[4:0]; // RQ1
        dec.bit_num = instr[7:5]; // RQ2
        dec.literal = instr[7:0]; // RQ3
        if (instr[11:9] == 3'b101) begin
            dec.jump = 1'b1; // RQ4
            dec.jump_target = instr[8:0]; // RQ4
        end else if (op4[3]) begin
            dec.use_literal = 1'b1;
            dec.dst = TBID_DST_W;
            case (op4)
                4'b1110: begin
                    dec.alu_op = TBID_ALU_AND; // RQ10
                    dec.upd_z = 1'b1;
                end
                4'b1101: begin
                    dec.alu_op = TBID_ALU_OR; // RQ10
                    dec.upd_z = 1'b1;
                end
                4'b1111: begin
                    dec.alu_op = TBID_ALU_XOR; // RQ10
                    dec.upd_z = 1'b1;
                end
                4'b1100: dec.alu_op = TBID_ALU_LIT; // RQ10
                4'b1001: begin
                    dec.dst = TBID_DST_NONE;
                    dec.call = 1'b1; // RQ11
                    dec.pc_bit8_clr = 1'b1; // RQ13
                end
                4'b1000: begin
                    dec.alu_op = TBID_ALU_LIT;
                    dec.ret = 1'b1; // RQ11
                    dec.pc_bit8_clr = 1'b1; // RQ13
                end
                default: begin
                    dec.use_literal = 1'b0;
                    dec.dst = TBID_DST_NONE;
                    dec.illegal = 1'b1; // RQ20
                end
            endcase
        end else if (op4[2]) begin
            dec.dst = TBID_DST_F;
            fmt_file = 1'b1;
            case (op4[1:0])
                2'b00: dec.alu_op = TBID_ALU_BCLR; // RQ2
                2'b01: dec.alu_op = TBID_ALU_BSET; // RQ2
                2'b10: begin
                    dec.alu_op = TBID_ALU_BTST;
                    dec.dst = TBID_DST_NONE;
                    dec.skip_if_clear = 1'b1; // RQ9
                end
                default: begin
                    dec.alu_op = TBID_ALU_BTST;
                    dec.dst = TBID_DST_NONE;
                    dec.skip_if_set = 1'b1; // RQ9
                end
            endcase
        end else if (instr[11:5] == 7'b0000000) begin
            case (instr[4:0])
                5'b00000: dec.alu_op = TBID_ALU_NOP; // RQ19
                5'b00010: begin
                    dec.alu_op = TBID_ALU_PASSW;
                    dec.dst = TBID_DST_OPTION; // RQ12
                end
                5'b00011: dec.standby = 1'b1; // RQ12
                5'b00100: dec.wdt_clear = 1'b1; // RQ12
                5'b00101: begin
                    dec.alu_op = TBID_ALU_PASSW;
                    dec.dst = TBID_DST_LOAD_DIRECTION_LATCH_A; // RQ15
                end
                5'b00110: begin
                    dec.alu_op = TBID_ALU_PASSW;
                    dec.dst = TBID_DST_LOAD_DIRECTION_LATCH_B; // RQ15
                end
                default: dec.illegal = 1'b1; // RQ20
            endcase
        end else if (instr[11:5] == 7'b0000001) begin
            dec.alu_op = TBID_ALU_PASSW; // RQ19
            dec.dst = TBID_DST_F;
            fmt_file = 1'b1;
        end else if (instr[11:5] == 7'b0000011) begin
            dec.alu_op = TBID_ALU_CLR; // RQ19
            dec.dst = TBID_DST_F;
            dec.upd_z = 1'b1;
            fmt_file = 1'b1;
        end else if (instr == 12'h0_040) begin
            dec.alu_op = TBID_ALU_CLR; // RQ19
            dec.dst = TBID_DST_W;
            dec.upd_z = 1'b1;
        end else if (instr[11:5] == 7'b0000010) begin
            dec.illegal = 1'b1; // RQ20
        end else begin
            fmt_file = 1'b1;
            dec.dst = instr[5] ? TBID_DST_F : TBID_DST_W; // RQ1
            dec.upd_z = 1'b1;
            case (op6)
                6'b000111: dec.alu_op = TBID_ALU_ADD; // RQ5
                6'b000010: dec.alu_op = TBID_ALU_SUB; // RQ5
                6'b000101: dec.alu_op = TBID_ALU_AND; // RQ6
                6'b000100: dec.alu_op = TBID_ALU_OR; // RQ6
                6'b000110: dec.alu_op = TBID_ALU_XOR; // RQ6
                6'b001001: dec.alu_op = TBID_ALU_COM; // RQ6
                6'b000011: dec.alu_op = TBID_ALU_DEC; // RQ6
                6'b001010: dec.alu_op = TBID_ALU_INC; // RQ6
                6'b001000: dec.alu_op = TBID_ALU_MOVE_FILE; // RQ6
                6'b001101: dec.alu_op = TBID_ALU_RL; // RQ7
                6'b001100: dec.alu_op = TBID_ALU_RR; // RQ7
                6'b001110: dec.alu_op = TBID_ALU_SWAP; // RQ7
                6'b001011: dec.alu_op = TBID_ALU_DEC; // RQ8
                6'b001111: dec.alu_op = TBID_ALU_INC; // RQ8
                default: dec.illegal = 1'b1;
            endcase
            case (op6)
                6'b000111, 6'b000010: begin
                    dec.upd_c = 1'b1; // RQ5
                    dec.upd_dc = 1'b1; // RQ5
                end
                6'b001101, 6'b001100: begin
                    dec.upd_c = 1'b1; // RQ7
                    dec.upd_z = 1'b0; // RQ7
                end
                6'b001110, 6'b001011,
                6'b001111: dec.upd_z = 1'b0; // RQ7 RQ8
                default: dec.upd_z = !dec.illegal;
            endcase
            dec.skip_if_zero = (op6 == 6'b001011) ||
                (op6 == 6'b001111); // RQ8
            if (dec.illegal) begin
                dec.dst = TBID_DST_NONE; // RQ20
                fmt_file = 1'b0;
            end
        end
        // writes to the pc register itself also clear bit 8
        if (fmt_file && dec.dst == TBID_DST_F && instr[4:0] == 5'h0_002)
            dec.pc_bit8_clr = 1'b1; // RQ13
        dec.read_pins = fmt_file && is_port &&
            dec.dst != TBID_DST_NONE; // RQ14
        dec.clr_prescaler = fmt_file && prescaler_on_timer &&
            instr[4:0] == TBID_TIMER_ADDR &&
            (dec.dst == TBID_DST_F || !op4[3] && op4[2:1] == 2'b10); // RQ16
    end

    // the decode word is sampled at phase 3; outcome known at the end
    assign cycle_end = clk_en && (phase_ff == 2'(TBID_PHASES - 1)); // RQ17
    assign two_cycle = ctl_ff.jump || ctl_ff.call || ctl_ff.ret ||
        ctl_ff.pc_bit8_clr || (ctl_ff.skip_if_zero && alu_zero) ||
        (ctl_ff.skip_if_clear && !bit_value) ||
        (ctl_ff.skip_if_set && bit_value); // RQ17

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= TBID_PHASE_RST;
        end else if (clk_en && !halt_ff) begin
            phase_ff <= phase_ff + 2'h1; // RQ17
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_ff <= '0;
            ctl_valid_ff <= 1'b0;
            second_ff <= 1'b0;
            flush_ff <= 1'b0;
            last_instr_ff <= 12'h0_000;
        end else if (cycle_end && !halt_ff) begin
            if (ctl_valid_ff && !second_ff && two_cycle) begin
                second_ff <= 1'b1; // RQ4
                flush_ff <= 1'b1; // RQ9
                ctl_valid_ff <= 1'b0;
            end else begin
                second_ff <= 1'b0;
                flush_ff <= 1'b0;
                ctl_valid_ff <= instr_valid;
                ctl_ff <= instr_valid ? dec : '0;
                last_instr_ff <= instr;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout_ff <= 1'b1;
            powerdown_ff <= 1'b1;
            osc_stop_ff <= 1'b0;
            halt_ff <= 1'b0;
        end else if (cycle_end && ctl_valid_ff && !second_ff) begin
            if (ctl_ff.standby) begin
                timeout_ff <= 1'b1; // RQ18
                powerdown_ff <= 1'b0; // RQ18
                osc_stop_ff <= 1'b1; // RQ18
                halt_ff <= 1'b1;
            end else if (ctl_ff.wdt_clear) begin
                timeout_ff <= 1'b1; // RQ12
                powerdown_ff <= 1'b1; // RQ12
            end
        end
    end

    assign ctl_out = ctl_ff;
    assign ctl_valid = ctl_valid_ff && !halt_ff;
    assign phase = phase_ff;
    assign flush_next = flush_ff;
    assign osc_stop = osc_stop_ff;
    assign timeout_flag = timeout_ff;
    assign powerdown_flag = powerdown_ff;
    assign ready = !halt_ff;

    // register bus: single-wait slave, ack one cycle after strobe
    // one answer per strobe: ack and err each stand a single cycle
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
    assign wb_hit = wb_adr_i == TBID_REG_INSTR ||
        wb_adr_i == TBID_REG_STATUS || wb_adr_i == TBID_REG_DECODE;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= wb_req && wb_hit;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    TBID_REG_INSTR: rdata_ff <= {20'h0_0000, last_instr_ff};
                    TBID_REG_STATUS: rdata_ff <= {24'h00_0000,
                        osc_stop_ff, halt_ff, second_ff, timeout_ff,
                        powerdown_ff, phase_ff, ctl_valid_ff};
                    TBID_REG_DECODE: rdata_ff <= {16'h0000,
                        3'h0, ctl_ff.alu_op, 5'h00, ctl_ff.dst};
                    default: rdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= wb_req && !wb_hit;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;
    assign wb_dat_o = rdata_ff;
endmodule : tbid_decoder
`default_nettype wire

/* File: testbench/tbid_decoder_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module tbid_decoder_properties
    import tbid_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // fetch side
    input wire logic [11:0] instr,
    input wire logic instr_valid,
    // execution feedback
    input wire logic alu_zero,
    input wire logic bit_value,
    // decode side
    input wire tbid_ctl_t ctl_out,
    input wire logic ctl_valid,
    input wire logic [1:0] phase,
    input wire logic flush_next,
    input wire logic osc_stop,
    input wire logic timeout_flag,
    input wire logic powerdown_flag,
    input wire logic ready,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic take;
    logic two_cyc;
    // running op needs a second cycle: the word on instr is not taken
    assign two_cyc = ctl_valid && (ctl_out.jump || ctl_out.call ||
        ctl_out.ret || ctl_out.pc_bit8_clr ||
        (ctl_out.skip_if_zero && alu_zero) ||
        (ctl_out.skip_if_clear && !bit_value) ||
        (ctl_out.skip_if_set && bit_value));
    // edge at which a fresh word is accepted
    assign take = clk_en && phase == 2'h3 && !flush_next && ready &&
        instr_valid && !two_cyc;
    phase_step_a: assert property (
        clk_en && ready |=> phase == $past(phase) + 2'h1)
        else $error("phase step");
    phase_hold_a: assert property (
        !clk_en |=> $stable(phase)) else $error("phase moved");
    jump_decode_a: assert property (
        take && instr[11:9] == 3'b101 |=> ctl_out.jump && !ctl_out.upd_z
        && ctl_out.jump_target == $past(instr[8:0]) && !ctl_out.pc_bit8_clr)
        else $error("jump decode");
    jump_flush_a: assert property (
        clk_en && phase == 2'h3 && ctl_valid && ctl_out.jump
        |=> flush_next && !ctl_valid) else $error("jump second cycle");
    bit_decode_a: assert property (
        take && instr[11:9] == 3'b010 |=> ctl_out.bit_num == $past(instr[7:5])
        && ctl_out.file_addr == $past(instr[4:0]) && !ctl_out.upd_z
        && ctl_out.alu_op == ($past(instr[8]) ? TBID_ALU_BSET : TBID_ALU_BCLR))
        else $error("bit decode");
    add_decode_a: assert property (
        take && instr[11:6] == 6'h07 |=> ctl_out.alu_op == TBID_ALU_ADD
        && ctl_out.dst == ($past(instr[5]) ? TBID_DST_F : TBID_DST_W)
        && ctl_out.upd_c && ctl_out.upd_dc && ctl_out.upd_z) else $error("add");
    lit_decode_a: assert property (
        take && instr[11:8] == 4'hc |=> ctl_out.literal == $past(instr[7:0])
        && ctl_out.dst == TBID_DST_W && !ctl_out.upd_z) else $error("literal");
    skip_zero_a: assert property (
        take && instr[11:6] == 6'h0b |=> ctl_out.skip_if_zero
        && !ctl_out.upd_z && !ctl_out.upd_c) else $error("skip zero");
    standby_a: assert property (
        take && instr == 12'h003 |-> ##[1:5] (osc_stop && timeout_flag
        && !powerdown_flag && !ready)) else $error("standby");
    halt_held_a: assert property (
        osc_stop |=> osc_stop && !ready) else $error("halt released");
    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    err_pulse_a: assert property (
        wb_err_o |=> !wb_err_o) else $error("err longer than one cycle");
    bus_answer_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
        else $error("bus not answered");
endmodule : tbid_decoder_properties
bind tbid_decoder tbid_decoder_properties u_props (.clk(clk), .rst_n(rst_n),
    .clk_en(clk_en), .instr(instr), .instr_valid(instr_valid),
    .ctl_out(ctl_out), .ctl_valid(ctl_valid), .phase(phase),
    .flush_next(flush_next), .osc_stop(osc_stop),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
    .alu_zero(alu_zero), .bit_value(bit_value),
    .ready(ready), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));
`default_nettype wire

/* File: testbench/tbid_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module tbid_prog_mem (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // word offered by the bench
    input wire logic [11:0] word,
    input wire logic word_ok,
    // fetch port
    output logic [11:0] instr,
    output logic instr_valid
);
    logic [11:0] instr_ff;
    logic valid_ff;
    // a slow or idle memory inverts its data each cycle, so the stale word returns every other cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_ff <= 12'hfff;
            valid_ff <= 1'b0;
        end else begin
            instr_ff <= word_ok ? word : ~instr_ff;
            valid_ff <= word_ok;
        end
    end
    assign instr = instr_ff;
    assign instr_valid = valid_ff;
endmodule : tbid_prog_mem
`default_nettype wire

/* File: testbench/tbid_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tbid_decoder_tb
    import tbid_pkg::*;
;
    logic clk = 0, rst_n = 0, clk_en = 0, alu_zero = 0, bit_value = 0;
    logic pot = 0, pm_ok = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [11:0] pm_word = 0, instr;
    logic [3:0] wb_adr_i = 0, wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o;
    logic instr_valid, ctl_valid, flush_next, osc_stop, timeout_flag;
    logic powerdown_flag, ready, wb_ack_o, wb_err_o;
    logic [1:0] phase;
    tbid_ctl_t ctl_out;
    int n_mismatch = 0, checks_done = 0;
    always #12.5 clk = ~clk;
    tbid_prog_mem u_pmem (.clk(clk), .rst_n(rst_n), .word(pm_word),
        .word_ok(pm_ok), .instr(instr), .instr_valid(instr_valid));
    tbid_decoder DUT (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .instr(instr), .instr_valid(instr_valid), .alu_zero(alu_zero),
        .bit_value(bit_value), .prescaler_on_timer(pot), .ctl_out(ctl_out),
        .ctl_valid(ctl_valid), .phase(phase), .flush_next(flush_next),
        .osc_stop(osc_stop), .timeout_flag(timeout_flag),
        .powerdown_flag(powerdown_flag), .ready(ready), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));
    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic wb_io(input logic [3:0] a, input logic we,
                         output logic [31:0] d, output logic e);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= 32'h5a5a_a5a5;
        // answer and data are taken at the rising edge that shows them
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        d = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_io
    // offer one word so that it is sampled at a phase 3 edge
    task automatic issue(input logic [11:0] w, input logic z, bv);
        do begin
            @(negedge clk);
        end while (!(phase === 2'h1 && flush_next === 1'b0));
        @(posedge clk);
        pm_word <= w;
        pm_ok <= 1'b1;
        alu_zero <= z;
        bit_value <= bv;
        repeat (2) @(posedge clk);
        pm_ok <= 1'b0;
        @(negedge clk);
    endtask : issue
    task automatic t_bus();
        logic [31:0] d;
        logic e;
        wb_io(4'h8, 1'b0, d, e);
        chk("status", {e, d[7:3]}, 6'h03);
        wb_io(4'h4, 1'b0, d, e);
        chk("unmapped", e, 1'b1);
        wb_io(4'h0, 1'b1, d, e);
        chk("ro_write", e, 1'b0);
        @(posedge clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge clk);
        clk_en <= 1'b1;
    endtask : t_bus
    task automatic t_decode();
        logic [11:0] w [21] = '{12'h1e3, 12'h084, 12'h163, 12'h1a3, 12'h243,
            12'h0c3, 12'h2a1, 12'h226, 12'h201, 12'h363, 12'h383, 12'hf5a,
            12'he0f, 12'hc3c, 12'h063, 12'h040, 12'h021, 12'h005, 12'h006,
            12'h002, 12'h001};
        tbid_alu_t a [21] = '{TBID_ALU_ADD, TBID_ALU_SUB, TBID_ALU_AND,
            TBID_ALU_XOR, TBID_ALU_COM, TBID_ALU_DEC, TBID_ALU_INC,
            TBID_ALU_MOVE_FILE, TBID_ALU_MOVE_FILE, TBID_ALU_RL, TBID_ALU_SWAP,
            TBID_ALU_XOR, TBID_ALU_AND, TBID_ALU_LIT, TBID_ALU_CLR,
            TBID_ALU_CLR, TBID_ALU_PASSW, TBID_ALU_PASSW, TBID_ALU_PASSW,
            TBID_ALU_PASSW, TBID_ALU_NOP};
        tbid_dst_t d [21] = '{TBID_DST_F, TBID_DST_W, TBID_DST_F, TBID_DST_F,
            TBID_DST_W, TBID_DST_W, TBID_DST_F, TBID_DST_F, TBID_DST_W,
            TBID_DST_F, TBID_DST_W, TBID_DST_W, TBID_DST_W, TBID_DST_W,
            TBID_DST_F, TBID_DST_W, TBID_DST_F, TBID_DST_LOAD_DIRECTION_LATCH_A,
            TBID_DST_LOAD_DIRECTION_LATCH_B, TBID_DST_OPTION, TBID_DST_NONE};
        // carry, digit carry, zero, pc bit8, pin read, prescaler clear
        logic [5:0] f [21] = '{6'h38, 6'h38, 6'h08, 6'h08, 6'h08, 6'h08,
            6'h09, 6'h0a, 6'h08, 6'h20, 6'h00, 6'h08, 6'h08, 6'h00, 6'h08,
            6'h08, 6'h01, 6'h00, 6'h00, 6'h00, 6'h00};
        for (int i = 0; i < 21; i++) begin
            issue(w[i], 1'b0, 1'b0);
            chk("alu_op", ctl_out.alu_op, a[i]);
            chk("dst", ctl_out.dst, d[i]);
            chk("flags", {ctl_out.upd_c, ctl_out.upd_dc, ctl_out.upd_z,
                ctl_out.pc_bit8_clr, ctl_out.read_pins,
                ctl_out.clr_prescaler}, f[i]);
            if (w[i][11] === 1'b1)
                chk("literal", ctl_out.literal, w[i][7:0]);
        end
    endtask : t_decode
    task automatic t_skip();
        logic [11:0] w [10] = '{12'h2e3, 12'h3e3, 12'h6e3, 12'h6e3, 12'h7e3,
            12'h4e3, 12'h5e3, 12'hb05, 12'h9ab, 12'h8ab};
        bit z [10] = '{1, 0, 0, 0, 0, 0, 0, 0, 0, 0};
        bit b [10] = '{1, 1, 0, 1, 1, 0, 0, 0, 0, 0};
        bit s [10] = '{1, 0, 1, 0, 1, 0, 0, 1, 1, 1};
        for (int i = 0; i < 10; i++) begin
            issue(w[i], z[i], b[i]);
            chk("valid", ctl_valid, 1'b1);
            chk("pc_bit8", ctl_out.pc_bit8_clr, w[i][11:9] == 3'h4);
            if (w[i][11:9] == 3'h5)
                chk("target", ctl_out.jump_target, w[i][8:0]);
            repeat (4) @(negedge clk);
            chk("flush", flush_next, s[i]);
        end
    endtask : t_skip
    task automatic t_sleep();
        logic [31:0] d;
        logic e;
        issue(12'h004, 1'b0, 1'b0);
        repeat (4) @(negedge clk);
        chk("wdt_flags", {timeout_flag, powerdown_flag}, 2'h3);
        issue(12'h003, 1'b0, 1'b0);
        repeat (4) @(negedge clk);
        chk("halt", {osc_stop, ready, timeout_flag, powerdown_flag},
            4'ha);
        wb_io(4'h8, 1'b0, d, e);
        chk("status", d[7:3], 5'h1a);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        wb_io(4'h8, 1'b0, d, e);
        chk("status", {e, d[7:3]}, 6'h03);
    endtask : t_sleep
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        clk_en <= 1'b1;
        pot <= 1'b1;
        t_bus();
        t_decode();
        t_skip();
        t_sleep();
        test_done();
    end
    initial begin
        #100000;
        n_mismatch++;
        test_done();
    end
endmodule : tbid_decoder_tb
`default_nettype wire
